//--- logic/bsfo_pkg.sv
// Purpose: Shared constants and carriers for the bit, shift and flag unit
// Assumes: 8-bit core, single clock, synchronous active-low reset
// Notes: Flag bit positions follow the usual I T H S V N Z C layout
package bsfo_pkg;

   // ****************************************
   // Widths and flag positions
   // ****************************************
   localparam int DATA_W = 8;
   localparam int SP_W = 8;
   localparam int IO_AW = 5;
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] SP_RST = 8'hFF;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;

   // ****************************************
   // Operation codes
   // ****************************************
   typedef enum logic [4:0] {
      BSFO_OP_NONE = 5'h00,
      BSFO_OP_STACK_STORE = 5'h01,
      BSFO_OP_STACK_LOAD = 5'h02,
      BSFO_OP_IO_BIT_SET = 5'h03,
      BSFO_OP_IO_BIT_CLEAR = 5'h04,
      BSFO_OP_LOGICAL_LEFT_SHIFT = 5'h05,
      BSFO_OP_LOGICAL_RIGHT_SHIFT = 5'h06,
      BSFO_OP_ROTATE_LEFT_WITH_CARRY = 5'h07,
      BSFO_OP_ROTATE_RIGHT_WITH_CARRY = 5'h08,
      BSFO_OP_ARITH_RIGHT_SHIFT = 5'h09,
      BSFO_OP_NIBBLE_EXCHANGE = 5'h0A,
      BSFO_OP_STATUS_BIT_ASSERT = 5'h0B,
      BSFO_OP_STATUS_BIT_DEASSERT = 5'h0C,
      BSFO_OP_BIT_TO_TRANSFER_FLAG = 5'h0D,
      BSFO_OP_TRANSFER_FLAG_TO_BIT = 5'h0E,
      BSFO_OP_CARRY_FLAG_FORCE_HIGH = 5'h0F,
      BSFO_OP_CARRY_FLAG_FORCE_LOW = 5'h10,
      BSFO_OP_NEGATIVE_FLAG_FORCE_HIGH = 5'h11,
      BSFO_OP_NEGATIVE_FLAG_FORCE_LOW = 5'h12
   } bsfo_op_t;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic valid;
      bsfo_op_t op;
      logic [2:0] bit_sel;
      logic [7:0] operand;
      logic [4:0] io_addr;
      logic [7:0] io_data;
      logic [7:0] stack_data;
   } bsfo_req_t;

   typedef struct packed {
      logic rd_we;
      logic [7:0] rd_data;
      logic io_we;
      logic [4:0] io_addr;
      logic [7:0] io_data;
      logic stack_we;
      logic stack_re;
      logic [7:0] stack_addr;
      logic [7:0] stack_data;
   } bsfo_res_t;

   typedef enum logic [1:0] {
      BSFO_ST_IDLE = 2'b00,
      BSFO_ST_LOAD = 2'b01
   } bsfo_state_t;

   typedef struct packed {
      bsfo_state_t st;
      logic [7:0] sp;
      logic [7:0] flags;
      bsfo_res_t res;
   } bsfo_regs_t;

endpackage : bsfo_pkg

//--- logic/bsfo_unit.sv
// Purpose: Execution unit for stack, bit, shift, rotate and flag operations
// Assumes: Decoder presents one request per cycle with operand values read, none writing the destination right after a stack load
// Notes: Results are registered; stack load answers one cycle after the read
//
// Contract
// - Stack store writes the source operand value onto the stack.
// - Stack load returns top stack byte to destination, flags unchanged.
// - I/O bit set forces bit b to one, other bits and flags kept.
// - I/O bit clear forces bit b to zero, other bits and flags kept.
// - Left shift moves bits up, zero into bit 0, updates Z C N V.
// - Right shift moves bits down, zero into bit 7, updates Z C N V.
// - Rotate left: carry into bit 0, bit 7 into carry, updates Z C N V.
// - Rotate right: carry into bit 7, bit 0 into carry, updates Z C N V.
// - Arithmetic right shift keeps bit 7, shifts others down, updates flags.
// - Nibble exchange swaps upper and lower halves, no flag changes.
// - Status bit assert sets selected flag bit only.
// - Status bit deassert clears selected flag bit only.
// - Bit to transfer flag copies operand bit b into T only.
// - Transfer flag to bit copies T into destination bit b.
// - Carry force high sets C, nothing else changes.
// - Carry force low clears C, nothing else changes.
// - Negative force high sets N, nothing else changes.
// - Negative force low clears N, nothing else changes.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module bsfo_unit #(
   parameter logic [7:0] SP_INIT = bsfo_pkg::SP_RST
) (
   input wire logic SYS_CLK_I,                 // Core clock, 25 MHz
   input wire logic RSTN_I,                    // Synchronous reset, active low
   input wire bsfo_pkg::bsfo_req_t REQ_I,      // Operation request from decoder
   output logic RD_WE_O,                       // Destination register write pulse
   output logic [7:0] RD_DATA_O,               // Destination register value
   output logic IO_WE_O,                       // I/O register write pulse
   output logic [4:0] IO_ADDR_O,               // I/O register address
   output logic [7:0] IO_DATA_O,               // I/O register new value
   output logic STACK_WE_O,                    // Stack memory write pulse
   output logic STACK_RE_O,                    // Stack memory read pulse
   output logic [7:0] STACK_ADDR_O,            // Stack memory address
   output logic [7:0] STACK_DATA_O,            // Stack memory write data
   output logic [7:0] SP_O,                    // Current stack pointer
   output logic [7:0] FLAGS_O                  // Flag register contents
);

   // ****************************************
   // State and helpers
   // ****************************************
   bsfo_pkg::bsfo_regs_t q_r;
   bsfo_pkg::bsfo_regs_t q_nxt;

   // Z, N, V and S after a shift with new carry
   function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] r, input logic c);
      logic [7:0] o;
      o = f;
      o[bsfo_pkg::FLAG_C] = c;
      o[bsfo_pkg::FLAG_Z] = (r == 8'h00);
      o[bsfo_pkg::FLAG_N] = r[7];
      o[bsfo_pkg::FLAG_V] = r[7] ^ c;
      o[bsfo_pkg::FLAG_S] = r[7] ^ (r[7] ^ c);
      return o;
   endfunction : shift_flags

   // Single-bit write into a byte
   function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] b, input logic x);
      logic [7:0] o;
      o = v;
      o[b] = x;
      return o;
   endfunction : put_bit

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      logic [7:0] d;
      logic [7:0] r;
      logic c;
      d = REQ_I.operand;
      r = 8'h00;
      c = q_r.flags[bsfo_pkg::FLAG_C];
      q_nxt = q_r;
      q_nxt.res.rd_we = 1'b0;
      q_nxt.res.io_we = 1'b0;
      q_nxt.res.stack_we = 1'b0;
      q_nxt.res.stack_re = 1'b0;
      q_nxt.st = bsfo_pkg::BSFO_ST_IDLE;
      // Popped byte arrives in the cycle of the read pulse
      if (q_r.st == bsfo_pkg::BSFO_ST_LOAD) begin
         q_nxt.res.rd_we = 1'b1;
         q_nxt.res.rd_data = REQ_I.stack_data;
      end
      if (REQ_I.valid) begin
         case (REQ_I.op)
            bsfo_pkg::BSFO_OP_STACK_STORE: begin
               q_nxt.res.stack_we = 1'b1;
               q_nxt.res.stack_addr = q_r.sp;
               q_nxt.res.stack_data = d;
               q_nxt.sp = q_r.sp - 8'h01;
            end
            bsfo_pkg::BSFO_OP_STACK_LOAD: begin
               q_nxt.sp = q_r.sp + 8'h01;
               q_nxt.res.stack_re = 1'b1;
               q_nxt.res.stack_addr = q_r.sp + 8'h01;
               q_nxt.st = bsfo_pkg::BSFO_ST_LOAD;
            end
            bsfo_pkg::BSFO_OP_IO_BIT_SET: begin
               q_nxt.res.io_we = 1'b1;
               q_nxt.res.io_addr = REQ_I.io_addr;
               q_nxt.res.io_data = put_bit(REQ_I.io_data, REQ_I.bit_sel, 1'b1);
            end
            bsfo_pkg::BSFO_OP_IO_BIT_CLEAR: begin
               q_nxt.res.io_we = 1'b1;
               q_nxt.res.io_addr = REQ_I.io_addr;
               q_nxt.res.io_data = put_bit(REQ_I.io_data, REQ_I.bit_sel, 1'b0);
            end
            bsfo_pkg::BSFO_OP_LOGICAL_LEFT_SHIFT: begin
               r = {d[6:0], 1'b0};
               c = d[7];
               q_nxt.res.rd_we = 1'b1;
               q_nxt.res.rd_data = r;
               q_nxt.flags = shift_flags(q_r.flags, r, c);
            end
            bsfo_pkg::BSFO_OP_LOGICAL_RIGHT_SHIFT: begin
               r = {1'b0, d[7:1]};
               c = d[0];
               q_nxt.res.rd_we = 1'b1;
               q_nxt.res.rd_data = r;
               q_nxt.flags = shift_flags(q_r.flags, r, c);
            end
            bsfo_pkg::BSFO_OP_ROTATE_LEFT_WITH_CARRY: begin
               r = {d[6:0], q_r.flags[bsfo_pkg::FLAG_C]};
               c = d[7];
               q_nxt.res.rd_we = 1'b1;
               q_nxt.res.rd_data = r;
               q_nxt.flags = shift_flags(q_r.flags, r, c);
            end
            bsfo_pkg::BSFO_OP_ROTATE_RIGHT_WITH_CARRY: begin
               r = {q_r.flags[bsfo_pkg::FLAG_C], d[7:1]};
               c = d[0];
               q_nxt.res.rd_we = 1'b1;
               q_nxt.res.rd_data = r;
               q_nxt.flags = shift_flags(q_r.flags, r, c);
            end
            bsfo_pkg::BSFO_OP_ARITH_RIGHT_SHIFT: begin
               r = {d[7], d[7:1]};
               c = d[0];
               q_nxt.res.rd_we = 1'b1;
               q_nxt.res.rd_data = r;
               q_nxt.flags = shift_flags(q_r.flags, r, c);
            end
            bsfo_pkg::BSFO_OP_NIBBLE_EXCHANGE: begin
               q_nxt.res.rd_we = 1'b1;
               q_nxt.res.rd_data = {d[3:0], d[7:4]};
            end
            bsfo_pkg::BSFO_OP_STATUS_BIT_ASSERT: begin
               q_nxt.flags = put_bit(q_r.flags, REQ_I.bit_sel, 1'b1);
            end
            bsfo_pkg::BSFO_OP_STATUS_BIT_DEASSERT: begin
               q_nxt.flags = put_bit(q_r.flags, REQ_I.bit_sel, 1'b0);
            end
            bsfo_pkg::BSFO_OP_BIT_TO_TRANSFER_FLAG: begin
               q_nxt.flags[bsfo_pkg::FLAG_T] = d[REQ_I.bit_sel];
            end
            bsfo_pkg::BSFO_OP_TRANSFER_FLAG_TO_BIT: begin
               q_nxt.res.rd_we = 1'b1;
               q_nxt.res.rd_data = put_bit(d, REQ_I.bit_sel, q_r.flags[bsfo_pkg::FLAG_T]);
            end
            bsfo_pkg::BSFO_OP_CARRY_FLAG_FORCE_HIGH: begin
               q_nxt.flags[bsfo_pkg::FLAG_C] = 1'b1;
            end
            bsfo_pkg::BSFO_OP_CARRY_FLAG_FORCE_LOW: begin
               q_nxt.flags[bsfo_pkg::FLAG_C] = 1'b0;
            end
            bsfo_pkg::BSFO_OP_NEGATIVE_FLAG_FORCE_HIGH: begin
               q_nxt.flags[bsfo_pkg::FLAG_N] = 1'b1;
            end
            bsfo_pkg::BSFO_OP_NEGATIVE_FLAG_FORCE_LOW: begin
               q_nxt.flags[bsfo_pkg::FLAG_N] = 1'b0;
            end
            default: begin
               q_nxt.st = q_nxt.st;
            end
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         q_r.st <= bsfo_pkg::BSFO_ST_IDLE;
         q_r.sp <= SP_INIT;
         q_r.flags <= bsfo_pkg::FLAGS_RST;
         q_r.res <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign RD_WE_O = q_r.res.rd_we;
   assign RD_DATA_O = q_r.res.rd_data;
   assign IO_WE_O = q_r.res.io_we;
   assign IO_ADDR_O = q_r.res.io_addr;
   assign IO_DATA_O = q_r.res.io_data;
   assign STACK_WE_O = q_r.res.stack_we;
   assign STACK_RE_O = q_r.res.stack_re;
   assign STACK_ADDR_O = q_r.res.stack_addr;
   assign STACK_DATA_O = q_r.res.stack_data;
   assign SP_O = q_r.sp;
   assign FLAGS_O = q_r.flags;

endmodule : bsfo_unit

`default_nettype wire

//--- dv/bsfo_stack_model.sv
// Purpose: Stack memory on the far side of the bit, shift and flag unit
// Assumes: Popped byte is wanted in the cycle of the read pulse
// Notes: Outside a read the data lines show the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module bsfo_stack_model (
   input wire logic clk_i,          // Core clock
   input wire logic we_i,           // Write pulse
   input wire logic re_i,           // Read pulse
   input wire logic [7:0] addr_i,   // Stack address
   input wire logic [7:0] data_i,   // Write data
   output logic [7:0] data_o        // Read data
);
   logic [7:0] mem_r [256];
   logic [7:0] last_r = 8'h00;
   // Store pushed bytes, remember the last popped one
   always @(posedge clk_i) begin
      if (we_i) begin
         mem_r[addr_i] <= data_i;
      end
      if (re_i) begin
         last_r <= mem_r[addr_i];
      end
   end
   // Released lines never repeat the last value
   assign data_o = re_i ? mem_r[addr_i] : ~last_r;
endmodule : bsfo_stack_model
`default_nettype wire

//--- dv/bsfo_unit_checker.sv
// Purpose: Port assertions for the bit, shift and flag unit
// Assumes: One clock domain, synchronous active-low reset
// Notes: A registered copy of the taken request keys each check except the reset one
`timescale 1ns/1ps
`default_nettype none
module bsfo_unit_checker #(
   parameter logic [7:0] SP_INIT = bsfo_pkg::SP_RST
) (
   input wire logic SYS_CLK_I,             // Clock
   input wire logic RSTN_I,                // Reset
   input wire bsfo_pkg::bsfo_req_t REQ_I,  // Request
   input wire logic RD_WE_O,               // Dest write
   input wire logic [7:0] RD_DATA_O,       // Dest value
   input wire logic IO_WE_O,               // I/O write
   input wire logic [4:0] IO_ADDR_O,       // I/O address
   input wire logic [7:0] IO_DATA_O,       // I/O value
   input wire logic STACK_WE_O,            // Stack write
   input wire logic STACK_RE_O,            // Stack read
   input wire logic [7:0] STACK_ADDR_O,    // Stack address
   input wire logic [7:0] STACK_DATA_O,    // Stack data
   input wire logic [7:0] SP_O,            // Stack pointer
   input wire logic [7:0] FLAGS_O          // Flags
);
   // ****************
   // Taken request
   // ****************
   bsfo_pkg::bsfo_req_t q_r;
   logic [7:0] f_r;
   logic [7:0] d;
   logic [2:0] b;
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RSTN_I);
   // Request and flags as of the last edge
   always_ff @(posedge SYS_CLK_I) begin
      q_r <= RSTN_I ? REQ_I : '0;
      f_r <= FLAGS_O;
   end
   assign d = q_r.operand;
   assign b = q_r.bit_sel;
   // Request passed in so the property samples it like any other operand
   function automatic logic tk(bsfo_pkg::bsfo_req_t q, bsfo_pkg::bsfo_op_t o);
      return q.valid && q.op == o;
   endfunction : tk
   sequence pop_read_s;
      STACK_RE_O && STACK_ADDR_O == SP_O && SP_O == $past(SP_O) + 8'h01;
   endsequence
   sequence pop_done_s;
      RD_WE_O && RD_DATA_O == $past(REQ_I.stack_data) && $stable(FLAGS_O);
   endsequence
   // ****************
   // Assertions
   // ****************
   push_write_a:
      assert property (tk(q_r, bsfo_pkg::BSFO_OP_STACK_STORE) |-> STACK_WE_O && STACK_DATA_O == d
         && STACK_ADDR_O == $past(SP_O) && SP_O == $past(SP_O) - 8'h01) else $error("push wrong");
   pop_flow_a:
      assert property (tk(q_r, bsfo_pkg::BSFO_OP_STACK_LOAD) |-> pop_read_s ##1 pop_done_s) else $error("pop wrong");
   io_set_a:
      assert property (tk(q_r, bsfo_pkg::BSFO_OP_IO_BIT_SET) |-> IO_WE_O && IO_ADDR_O == q_r.io_addr
         && IO_DATA_O == (q_r.io_data | (8'h01 << b)) && FLAGS_O == f_r) else $error("io set wrong");
   io_clear_a:
      assert property (tk(q_r, bsfo_pkg::BSFO_OP_IO_BIT_CLEAR) |-> IO_WE_O
         && IO_DATA_O == (q_r.io_data & ~(8'h01 << b)) && FLAGS_O == f_r) else $error("io clear wrong");
   shl_result_a:
      assert property (tk(q_r, bsfo_pkg::BSFO_OP_LOGICAL_LEFT_SHIFT) |-> RD_WE_O && RD_DATA_O == {d[6:0], 1'b0}
         && FLAGS_O[0] == d[7]) else $error("left shift wrong");
   rotr_result_a:
      assert property (tk(q_r, bsfo_pkg::BSFO_OP_ROTATE_RIGHT_WITH_CARRY) |-> RD_DATA_O == {f_r[0], d[7:1]}
         && FLAGS_O[0] == d[0]) else $error("rotate right wrong");
   asr_result_a:
      assert property (tk(q_r, bsfo_pkg::BSFO_OP_ARITH_RIGHT_SHIFT) |-> RD_DATA_O == {d[7], d[7:1]}
         && FLAGS_O[0] == d[0]) else $error("arith shift wrong");
   shift_flags_a:
      assert property (q_r.valid && q_r.op inside {[5'h05:5'h09]} |-> FLAGS_O[1] == (RD_DATA_O == 8'h00)
         && FLAGS_O[2] == RD_DATA_O[7] && FLAGS_O[3] == (FLAGS_O[2] ^ FLAGS_O[0])) else $error("shift flags wrong");
   swap_keep_a:
      assert property (tk(q_r, bsfo_pkg::BSFO_OP_NIBBLE_EXCHANGE) |-> RD_DATA_O == {d[3:0], d[7:4]}
         && FLAGS_O == f_r) else $error("swap wrong");
   tflag_copy_a:
      assert property (tk(q_r, bsfo_pkg::BSFO_OP_BIT_TO_TRANSFER_FLAG) |-> !RD_WE_O
         && FLAGS_O == {f_r[7], d[b], f_r[5:0]}) else $error("transfer flag wrong");
   reset_values_a:
      assert property (disable iff (1'b0) !RSTN_I |=> SP_O == SP_INIT && FLAGS_O == bsfo_pkg::FLAGS_RST
         && !RD_WE_O && !STACK_WE_O) else $error("reset values wrong");
endmodule : bsfo_unit_checker
bind bsfo_unit bsfo_unit_checker #(.SP_INIT(SP_INIT)) u_chk (
   .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .REQ_I(REQ_I), .RD_WE_O(RD_WE_O), .RD_DATA_O(RD_DATA_O),
   .IO_WE_O(IO_WE_O), .IO_ADDR_O(IO_ADDR_O), .IO_DATA_O(IO_DATA_O), .STACK_WE_O(STACK_WE_O),
   .STACK_RE_O(STACK_RE_O), .STACK_ADDR_O(STACK_ADDR_O), .STACK_DATA_O(STACK_DATA_O), .SP_O(SP_O),
   .FLAGS_O(FLAGS_O)
);
`default_nettype wire

//--- dv/testbench.sv
// Purpose: Self-checking bench for the bit, shift and flag unit
// Assumes: One request per two cycles, pops followed by a gap
// Notes: Random operations with fixed seed plus corner values
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk;
   logic rstn;
   bsfo_pkg::bsfo_req_t req;
   bsfo_pkg::bsfo_req_t dreq;
   logic rd_we, io_we, st_we, st_re;
   logic [7:0] rd_d, io_d, st_a, st_d, sp, fl, pm_d, efl;
   logic [4:0] io_a;
   logic [7:0] sh[$];
   int fails;
   int checks_done;
   // Clock at 25 MHz
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Popped byte comes from the stack model
   always_comb begin
      dreq = req;
      dreq.stack_data = pm_d;
   end
   bsfo_unit #(.SP_INIT(bsfo_pkg::SP_RST)) u_dut (.SYS_CLK_I(clk), .RSTN_I(rstn), .REQ_I(dreq),
      .RD_WE_O(rd_we), .RD_DATA_O(rd_d), .IO_WE_O(io_we), .IO_ADDR_O(io_a), .IO_DATA_O(io_d),
      .STACK_WE_O(st_we), .STACK_RE_O(st_re), .STACK_ADDR_O(st_a), .STACK_DATA_O(st_d), .SP_O(sp), .FLAGS_O(fl));
   bsfo_stack_model u_stack (.clk_i(clk), .we_i(st_we), .re_i(st_re), .addr_i(st_a), .data_i(st_d), .data_o(pm_d));
   // ****************
   // Helpers
   // ****************
   task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, s);
         fails++;
      end
   endtask : chk
   // Expected {result, flags} of a register operation
   function automatic logic [15:0] calc(bsfo_pkg::bsfo_op_t o, logic [2:0] b, logic [7:0] d, logic [7:0] f);
      logic [7:0] r;
      logic [7:0] n;
      r = d;
      n = f;
      case (o)
         5'h05: r = {d[6:0], 1'b0};
         5'h06: r = {1'b0, d[7:1]};
         5'h07: r = {d[6:0], f[0]};
         5'h08: r = {f[0], d[7:1]};
         5'h09: r = {d[7], d[7:1]};
         5'h0A: r = {d[3:0], d[7:4]};
         5'h0B: n[b] = 1'b1;
         5'h0C: n[b] = 1'b0;
         5'h0D: n[6] = d[b];
         5'h0E: r[b] = f[6];
         5'h0F: n[0] = 1'b1;
         5'h10: n[0] = 1'b0;
         5'h11: n[2] = 1'b1;
         5'h12: n[2] = 1'b0;
         default: ;
      endcase
      if (o inside {[5'h05:5'h09]}) begin
         n[0] = (o == 5'h05 || o == 5'h07) ? d[7] : d[0];
         n[1] = (r == 8'h00);
         n[2] = r[7];
         n[3] = r[7] ^ n[0];
         n[4] = n[2] ^ n[3];
      end
      return {r, n};
   endfunction : calc
   task automatic issue(bsfo_pkg::bsfo_op_t o, logic [2:0] b, logic [7:0] d, logic [7:0] io);
      @(posedge clk);
      req <= '{1'b1, o, b, d, io[4:0], io, 8'h00};
      @(posedge clk);
      req.valid <= 1'b0;
      #1;
   endtask : issue
   task automatic run(bsfo_pkg::bsfo_op_t o, logic [2:0] b, logic [7:0] d, logic [7:0] io);
      logic [15:0] e;
      logic w;
      e = calc(o, b, d, efl);
      w = o inside {[5'h05:5'h0A], 5'h0E};
      issue(o, b, d, io);
      chk("flags", e[7:0], fl);
      chk("rd_we", {7'h00, w}, {7'h00, rd_we});
      if (w) chk("rd", e[15:8], rd_d);
      chk("io_we", {7'h00, o inside {5'h03, 5'h04}}, {7'h00, io_we});
      if (o == 5'h03) chk("io", io | (8'h01 << b), io_d);
      if (o == 5'h04) chk("io", io & ~(8'h01 << b), io_d);
      efl = e[7:0];
   endtask : run
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_of_test();
   end
   // ****************
   // Main sequence
   // ****************
   initial begin
      req = '0;
      rstn = 1'b0;
      efl = bsfo_pkg::FLAGS_RST;
      fails = 0;
      checks_done = 0;
      void'($urandom(20));
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      #1;
      chk("sp_rst", bsfo_pkg::SP_RST, sp);
      chk("fl_rst", bsfo_pkg::FLAGS_RST, fl);
      // Corners: carry out to zero result, sign kept, unknown code
      run(bsfo_pkg::bsfo_op_t'(5'h05), 3'h0, 8'h80, 8'h00);
      run(bsfo_pkg::bsfo_op_t'(5'h09), 3'h0, 8'h81, 8'h00);
      run(bsfo_pkg::bsfo_op_t'(5'h1F), 3'h7, 8'hFF, 8'hFF);
      for (int k = 0; k < 300; k++) begin
         run(bsfo_pkg::bsfo_op_t'(5'($urandom_range(3, 18))), 3'($urandom), 8'($urandom), 8'($urandom));
      end
      for (int i = 0; i < 4; i++) begin
         sh.push_back(8'($urandom));
         issue(bsfo_pkg::BSFO_OP_STACK_STORE, 3'h0, sh[i], 8'h00);
         chk("push", sh[i], st_d);
         chk("push_addr", 8'hFF - 8'(i), st_a);
      end
      for (int i = 3; i >= 0; i--) begin
         issue(bsfo_pkg::BSFO_OP_STACK_LOAD, 3'h0, 8'h00, 8'h00);
         chk("sp", 8'hFF - 8'(i), sp);
         @(posedge clk);
         #1;
         chk("pop_we", 8'h01, {7'h00, rd_we});
         chk("pop", sh[i], rd_d);
         chk("pop_flags", efl, fl);
      end
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
